// ==== common/tcc_pkg.sv ====
package tcc_pkg;

  // Register offsets, one byte each
  localparam logic [4:0] CTRL_ONE_OFS = 5'h00;
  localparam logic [4:0] CTRL_TWO_OFS = 5'h01;
  localparam logic [4:0] STATUS_OFS = 5'h02;
  localparam logic [4:0] CAP_ONE_HI_OFS = 5'h04;
  localparam logic [4:0] CAP_ONE_LO_OFS = 5'h05;
  localparam logic [4:0] CMP_ONE_HI_OFS = 5'h06;
  localparam logic [4:0] CMP_ONE_LO_OFS = 5'h07;
  localparam logic [4:0] CNT_HI_OFS = 5'h08;
  localparam logic [4:0] CNT_LO_OFS = 5'h09;
  localparam logic [4:0] ALT_CNT_HI_OFS = 5'h0A;
  localparam logic [4:0] ALT_CNT_LO_OFS = 5'h0B;
  localparam logic [4:0] CAP_TWO_HI_OFS = 5'h0C;
  localparam logic [4:0] CAP_TWO_LO_OFS = 5'h0D;
  localparam logic [4:0] CMP_TWO_HI_OFS = 5'h0E;
  localparam logic [4:0] CMP_TWO_LO_OFS = 5'h0F;

  // control_reg_one fields
  localparam int C1_LEVEL_ONE = 0;
  localparam int C1_EDGE_ONE = 1;
  localparam int C1_LEVEL_TWO = 2;
  localparam int C1_FORCE_ONE = 3;
  localparam int C1_FORCE_TWO = 4;
  localparam int C1_OVF_IE = 5;
  localparam int C1_CMP_IE = 6;
  localparam int C1_CAP_IE = 7;

  // control_reg_two fields
  localparam int C2_EXT_EDGE = 0;
  localparam int C2_EDGE_TWO = 1;
  localparam int C2_PRESC_LSB = 2;
  localparam int C2_PWM = 4;
  localparam int C2_ONE_PULSE = 5;
  localparam int C2_PIN_EN_TWO = 6;
  localparam int C2_PIN_EN_ONE = 7;

  // timer_status_reg fields
  localparam int SR_CMP_TWO = 3;
  localparam int SR_CAP_TWO = 4;
  localparam int SR_OVF = 5;
  localparam int SR_CMP_ONE = 6;
  localparam int SR_CAP_ONE = 7;

  // timer_prescale_select codes
  localparam logic [1:0] PRESC_DIV4 = 2'h0;
  localparam logic [1:0] PRESC_DIV2 = 2'h1;
  localparam logic [1:0] PRESC_DIV8 = 2'h2;
  localparam logic [1:0] PRESC_EXT = 2'h3;
  localparam logic [2:0] DIV2_MASK = 3'h1;
  localparam logic [2:0] DIV4_MASK = 3'h3;
  localparam logic [2:0] DIV8_MASK = 3'h7;

  // Reset values
  localparam logic [15:0] COUNTER_RESET = 16'hFFFC;
  localparam logic [15:0] COMPARE_RESET = 16'h8000;
  localparam logic [15:0] CAPTURE_RESET = 16'h0000;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  typedef struct packed {
    logic [7:0] ctrlOne;
    logic [7:0] ctrlTwo;
    logic [1:0][15:0] capVal;
    logic [1:0][15:0] cmpVal;
    logic [15:0] counter;
    logic [2:0] div;
    logic tickDly;
    logic [1:0] capFlag;
    logic [1:0] cmpFlag;
    logic ovfFlag;
    logic [1:0] capArm;
    logic [1:0] cmpArm;
    logic ovfArm;
    logic [1:0] capLock;
    logic [1:0] cmpHold;
    logic [7:0] cntLowBuf;
    logic cntSeq;
    logic [1:0] pinOut;
    logic [1:0] capSyncA;
    logic [1:0] capSyncB;
    logic [1:0] capPrev;
    logic extSyncA;
    logic extSyncB;
    logic extPrev;
    logic [7:0] rdData;
  } tcc_state_s;

endpackage

// ==== hdl/tcc_top.sv ====
// Implementation choices: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none

module tcc_top
  import tcc_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Register port
  input wire logic [4:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrStb,
  input wire logic regRdStb,
  output logic [7:0] regRdData,
  // Pins
  input wire logic capturePinOne,
  input wire logic capturePinTwo,
  input wire logic externalTimerClockPin,
  output logic comparePinOneOut,
  output logic comparePinOneOe,
  output logic comparePinTwoOut,
  output logic comparePinTwoOe,
  // CPU interrupt
  input wire logic cpuIrqMask,
  output logic timerIrq
);

  tcc_state_s q;
  tcc_state_s d;

  logic [2:0] divMask;
  logic tick;
  logic extEdge;
  logic altMode;
  logic [1:0] capEdge;
  logic [1:0] capEnable;
  logic [1:0] capEvent;
  logic [1:0] cmpEvent;
  logic [1:0] pinEnable;
  logic [1:0] level;
  logic [1:0][15:0] cmpTarget;
  logic [1:0] edgeRising;
  logic wr;
  logic rd;

  assign wr = regWrStb;
  assign rd = regRdStb;
  assign altMode = q.ctrlTwo[C2_ONE_PULSE] | q.ctrlTwo[C2_PWM];
  assign pinEnable = {q.ctrlTwo[C2_PIN_EN_TWO], q.ctrlTwo[C2_PIN_EN_ONE]};
  assign level = {q.ctrlOne[C1_LEVEL_TWO], q.ctrlOne[C1_LEVEL_ONE]};
  assign edgeRising = {q.ctrlTwo[C2_EDGE_TWO], q.ctrlOne[C1_EDGE_ONE]};
  assign capEnable = {1'b1, ~altMode};

  // Prescaler and external clock edge
  always_comb
  begin
    case (q.ctrlTwo[C2_PRESC_LSB +: 2])
      PRESC_DIV2: divMask = DIV2_MASK;
      PRESC_DIV4: divMask = DIV4_MASK;
      PRESC_DIV8: divMask = DIV8_MASK;
      default: divMask = DIV8_MASK;
    endcase
  end

  // External pin must stay under a quarter of core_clk; slower edges are seen once
  assign extEdge = q.ctrlTwo[C2_EXT_EDGE] ? (q.extSyncB & ~q.extPrev)
                                          : (~q.extSyncB & q.extPrev);
  assign tick = (q.ctrlTwo[C2_PRESC_LSB +: 2] == PRESC_EXT) ? extEdge
                                                            : ((q.div & divMask) == divMask);

  // Capture edge detection on synchronised pins
  always_comb
  begin
    for (int i = 0; i < 2; i++)
    begin
      capEvent[i] = capEnable[i] & ~q.capLock[i] &
                    (edgeRising[i] ? (q.capSyncB[i] & ~q.capPrev[i])
                                   : (~q.capSyncB[i] & q.capPrev[i]));
    end
  end

  // Compare match on the first core cycle of each counter value
  always_comb
  begin
    for (int i = 0; i < 2; i++)
    begin
      if (q.ctrlTwo[C2_PRESC_LSB +: 2] == PRESC_DIV2)
      begin
        cmpTarget[i] = q.cmpVal[i];
      end
      else
      begin
        cmpTarget[i] = q.cmpVal[i] + 16'h0001;
      end
      cmpEvent[i] = q.tickDly & ~q.cmpHold[i] & (q.counter == cmpTarget[i]);
    end
  end

  always_comb
  begin
    d = q;
    d.rdData = 8'h00;

    // Synchronisers: second stage is the only reader of the first
    d.capSyncA = {capturePinTwo, capturePinOne};
    d.capSyncB = q.capSyncA;
    d.capPrev = q.capSyncB;
    d.extSyncA = externalTimerClockPin;
    d.extSyncB = q.extSyncA;
    d.extPrev = q.extSyncB;

    d.div = q.div + 3'h1;
    d.tickDly = tick;
    if (tick)
    begin
      d.counter = q.counter + 16'h0001;
    end

    // Register writes
    if (wr)
    begin
      case (regAddr)
        CTRL_ONE_OFS:
        begin
          d.ctrlOne = regWrData;
          d.ctrlOne[C1_FORCE_ONE] = 1'b0;
          d.ctrlOne[C1_FORCE_TWO] = 1'b0;
          if (!altMode)
          begin
            if (regWrData[C1_FORCE_ONE])
            begin
              d.pinOut[0] = regWrData[C1_LEVEL_ONE];
            end
            if (regWrData[C1_FORCE_TWO])
            begin
              d.pinOut[1] = regWrData[C1_LEVEL_TWO];
            end
          end
        end
        CTRL_TWO_OFS: d.ctrlTwo = regWrData;
        CMP_ONE_HI_OFS:
        begin
          d.cmpVal[0][15:8] = regWrData;
          d.cmpHold[0] = 1'b1;
        end
        CMP_ONE_LO_OFS:
        begin
          d.cmpVal[0][7:0] = regWrData;
          d.cmpHold[0] = 1'b0;
        end
        CMP_TWO_HI_OFS:
        begin
          d.cmpVal[1][15:8] = regWrData;
          d.cmpHold[1] = 1'b1;
        end
        CMP_TWO_LO_OFS:
        begin
          d.cmpVal[1][7:0] = regWrData;
          d.cmpHold[1] = 1'b0;
        end
        CNT_LO_OFS, ALT_CNT_LO_OFS: d.counter = COUNTER_RESET;
        default: d.counter = d.counter; // Capture and status writes ignored
      endcase
    end

    // Register reads
    if (rd)
    begin
      case (regAddr)
        CTRL_ONE_OFS: d.rdData = q.ctrlOne;
        CTRL_TWO_OFS: d.rdData = q.ctrlTwo;
        STATUS_OFS:
        begin
          d.rdData = {q.capFlag[0], q.cmpFlag[0], q.ovfFlag, q.capFlag[1], q.cmpFlag[1], 3'h0};
          d.capArm = q.capArm | q.capFlag;
          d.cmpArm = q.cmpArm | q.cmpFlag;
          d.ovfArm = q.ovfArm | q.ovfFlag;
        end
        CAP_ONE_HI_OFS:
        begin
          d.rdData = q.capVal[0][15:8];
          d.capLock[0] = 1'b1;
        end
        CAP_ONE_LO_OFS:
        begin
          d.rdData = q.capVal[0][7:0];
          d.capLock[0] = 1'b0;
        end
        CAP_TWO_HI_OFS:
        begin
          d.rdData = q.capVal[1][15:8];
          d.capLock[1] = 1'b1;
        end
        CAP_TWO_LO_OFS:
        begin
          d.rdData = q.capVal[1][7:0];
          d.capLock[1] = 1'b0;
        end
        CMP_ONE_HI_OFS: d.rdData = q.cmpVal[0][15:8];
        CMP_ONE_LO_OFS: d.rdData = q.cmpVal[0][7:0];
        CMP_TWO_HI_OFS: d.rdData = q.cmpVal[1][15:8];
        CMP_TWO_LO_OFS: d.rdData = q.cmpVal[1][7:0];
        CNT_HI_OFS, ALT_CNT_HI_OFS:
        begin
          // Low byte frozen at the first high read of a sequence
          d.rdData = q.counter[15:8];
          if (!q.cntSeq)
          begin
            d.cntLowBuf = q.counter[7:0];
            d.cntSeq = 1'b1;
          end
        end
        CNT_LO_OFS, ALT_CNT_LO_OFS:
        begin
          d.rdData = q.cntSeq ? q.cntLowBuf : q.counter[7:0];
          d.cntSeq = 1'b0;
        end
        default: d.rdData = 8'h00;
      endcase
    end

    // Second step of flag clearing, read or write of the low byte
    if (rd | wr)
    begin
      if (regAddr == CAP_ONE_LO_OFS && q.capArm[0])
      begin
        d.capFlag[0] = 1'b0;
        d.capArm[0] = 1'b0;
      end
      if (regAddr == CAP_TWO_LO_OFS && q.capArm[1])
      begin
        d.capFlag[1] = 1'b0;
        d.capArm[1] = 1'b0;
      end
      if (regAddr == CMP_ONE_LO_OFS && q.cmpArm[0])
      begin
        d.cmpFlag[0] = 1'b0;
        d.cmpArm[0] = 1'b0;
      end
      if (regAddr == CMP_TWO_LO_OFS && q.cmpArm[1])
      begin
        d.cmpFlag[1] = 1'b0;
        d.cmpArm[1] = 1'b0;
      end
      if (regAddr == CNT_LO_OFS && q.ovfArm)
      begin
        d.ovfFlag = 1'b0;
        d.ovfArm = 1'b0;
      end
    end

    // Hardware sets come last so they beat a clear in the same cycle
    if (tick && q.counter == 16'hFFFF)
    begin
      d.ovfFlag = 1'b1;
    end
    for (int i = 0; i < 2; i++)
    begin
      if (capEvent[i])
      begin
        d.capVal[i] = q.counter;
        d.capFlag[i] = 1'b1;
      end
      if (cmpEvent[i])
      begin
        d.cmpFlag[i] = 1'b1;
        if (pinEnable[i])
        begin
          d.pinOut[i] = level[i];
        end
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      q <= '0;
      q.ctrlOne <= CTRL_RESET;
      q.ctrlTwo <= CTRL_RESET;
      q.capVal <= {CAPTURE_RESET, CAPTURE_RESET};
      q.cmpVal <= {COMPARE_RESET, COMPARE_RESET};
      q.counter <= COUNTER_RESET;
      q.pinOut <= 2'b00;
    end
    else
    begin
      q <= d;
    end
  end

  assign regRdData = q.rdData;
  assign comparePinOneOut = q.pinOut[0];
  assign comparePinTwoOut = q.pinOut[1];
  // Pin left to general I/O when not enabled
  assign comparePinOneOe = pinEnable[0];
  assign comparePinTwoOe = pinEnable[1];

  // Flags pend until enable set and mask clear
  assign timerIrq = ~cpuIrqMask &
                    ((q.ctrlOne[C1_CAP_IE] & (|q.capFlag)) |
                     (q.ctrlOne[C1_CMP_IE] & (|q.cmpFlag)) |
                     (q.ctrlOne[C1_OVF_IE] & q.ovfFlag));

endmodule

`default_nettype wire

// ==== test/tcc_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module tcc_asserts
  import tcc_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // Register port
  input wire logic [4:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrStb,
  input wire logic regRdStb,
  input wire logic [7:0] regRdData,
  // Pins
  input wire logic capturePinOne,
  input wire logic capturePinTwo,
  input wire logic externalTimerClockPin,
  input wire logic comparePinOneOut,
  input wire logic comparePinOneOe,
  input wire logic comparePinTwoOut,
  input wire logic comparePinTwoOe,
  // Interrupt
  input wire logic cpuIrqMask,
  input wire logic timerIrq
);
  logic [7:0] ctlQ;
  logic modeQ;
  // Shadow of the enables and modes, as software wrote them
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      ctlQ <= CTRL_RESET;
      modeQ <= 1'b0;
    end
    else if (regWrStb && regAddr == CTRL_ONE_OFS)
      ctlQ <= regWrData;
    else if (regWrStb && regAddr == CTRL_TWO_OFS)
      modeQ <= regWrData[C2_PWM] | regWrData[C2_ONE_PULSE];
  end
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (rst);
  sequence s_wrHi;
    regWrStb && regAddr == CMP_ONE_HI_OFS;
  endsequence
  sequence s_rdHi;
    regRdStb && regAddr == CMP_ONE_HI_OFS;
  endsequence
  property p_pinRst;
    disable iff (1'b0) rst |-> !comparePinOneOut && !comparePinTwoOut;
  endproperty
  a_pinRst: assert property (p_pinRst) else $error("pin high in reset");
  property p_mask;
    cpuIrqMask |-> !timerIrq;
  endproperty
  a_mask: assert property (p_mask) else $error("irq while masked");
  property p_noEn;
    ctlQ[7:5] == 3'b000 |-> !timerIrq;
  endproperty
  a_noEn: assert property (p_noEn) else $error("irq not enabled");
  property p_oeSet;
    regWrStb && regAddr == CTRL_TWO_OFS |=>
      {comparePinOneOe, comparePinTwoOe} == $past(regWrData[7:6]);
  endproperty
  a_oeSet: assert property (p_oeSet) else $error("oe wrong");
  property p_oeHold;
    !(regWrStb && regAddr == CTRL_TWO_OFS) |=> $stable({comparePinOneOe, comparePinTwoOe});
  endproperty
  a_oeHold: assert property (p_oeHold) else $error("oe moved");
  property p_force;
    regWrStb && regAddr == CTRL_ONE_OFS && regWrData[C1_FORCE_ONE] && !modeQ |=>
      comparePinOneOut == $past(regWrData[C1_LEVEL_ONE]);
  endproperty
  a_force: assert property (p_force) else $error("force lost");
  property p_back;
    s_wrHi ##1 s_rdHi |=> regRdData == $past(regWrData, 2);
  endproperty
  a_back: assert property (p_back) else $error("readback");
  property p_idle;
    !regRdStb |=> regRdData == 8'h00;
  endproperty
  a_idle: assert property (p_idle) else $error("stray data");
endmodule
bind tcc_top tcc_asserts u_chk (.*);
`default_nettype wire

// ==== test/tcc_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module tcc_bench
  import tcc_pkg::*;
;
  logic core_clk = 1'b0;
  logic rst = 1'b0;
  logic [4:0] regAddr = 5'h00;
  logic [7:0] regWrData = 8'h00;
  logic regWrStb = 1'b0;
  logic regRdStb = 1'b0;
  logic cpuIrqMask = 1'b0;
  logic extRun = 1'b0;
  logic [1:0] pinReq = 2'h0;
  logic [7:0] regRdData, d;
  logic capturePinOne, capturePinTwo, externalTimerClockPin, timerIrq;
  logic comparePinOneOut, comparePinOneOe, comparePinTwoOut, comparePinTwoOe;
  logic [31:0] lfsrQ = 32'hde93_5c8d;
  logic [4:0] p, q;
  logic [1:0] pscT[4] = '{PRESC_DIV2, PRESC_DIV4, PRESC_DIV8, PRESC_EXT};
  int nT[4] = '{2, 4, 8, 8};
  int cmpM[2] = '{32768, 32768};
  int err_count = 0;
  int n_compared = 0;
  int c0, c1, v, e, cyc;
  always #5 core_clk = !core_clk;
  tcc_top dut (.*);
  tcc_pins far (.core_clk(core_clk), .extRun(extRun), .pinReq(pinReq),
    .capturePinOne(capturePinOne), .capturePinTwo(capturePinTwo),
    .externalTimerClockPin(externalTimerClockPin));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic summarize();
    if (err_count == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] x, input logic [15:0] y);
    n_compared++;
    if (y !== x)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", n, x, y);
    end
  endtask
  // Strobes stay up until the next task drops them
  task automatic wr(input logic [4:0] a, input logic [7:0] w);
    regAddr <= a;
    regWrData <= w;
    regWrStb <= 1'b1;
    regRdStb <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [4:0] a);
    regAddr <= a;
    regRdStb <= 1'b1;
    regWrStb <= 1'b0;
    @(posedge core_clk);
    #1 d = regRdData;
  endtask
  task automatic rdc(input logic [4:0] a, input logic [7:0] x);
    rd(a);
    chk("reg", x, d);
  endtask
  task automatic tick(input int n);
    regWrStb <= 1'b0;
    regRdStb <= 1'b0;
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic rdCnt(output int c);
    rd(CNT_HI_OFS);
    c = d * 256;
    rd(CNT_LO_OFS);
    c += d;
  endtask
  initial
  begin
    repeat (5000) @(posedge core_clk);
    err_count++;
    summarize();
  end
  initial
  begin
    // Reset raised by NBA so the async reset sees a real edge at time zero
    rst <= 1'b1;
    tick(3);
    rst <= 1'b0;
    tick(1);
    for (int i = 0; i < 2; i++)
    begin
      p = i ? CMP_TWO_HI_OFS : CMP_ONE_HI_OFS;
      q = i ? CAP_TWO_HI_OFS : CAP_ONE_HI_OFS;
      rdc(p, cmpM[i][15:8]);
      rdc(p + 5'h01, cmpM[i][7:0]);
      lfsrQ = lfsr(lfsrQ);
      cmpM[i] = lfsrQ[15:0];
      wr(p, lfsrQ[15:8]);
      rdc(p, cmpM[i][15:8]);
      wr(p + 5'h01, lfsrQ[7:0]);
      rdc(p + 5'h01, cmpM[i][7:0]);
      wr(q, lfsrQ[23:16]);
      rdc(q, 8'h00);
      rdc(q + 5'h01, 8'h00);
    end
    for (int k = 0; k < 4; k++)
    begin
      extRun <= (k == 3);
      wr(CTRL_TWO_OFS, {4'h8, pscT[k], 2'b00});
      wr(CTRL_ONE_OFS, 8'h08);
      wr(CTRL_ONE_OFS, 8'h45);
      chk("force", 16'h0000, comparePinOneOut);
      wr(CMP_ONE_HI_OFS, 8'h00);
      wr(CMP_TWO_HI_OFS, 8'h00);
      rd(STATUS_OFS);
      wr(CMP_ONE_LO_OFS, 8'h00);
      wr(CMP_TWO_LO_OFS, 8'h00);
      cmpM = '{0, 0};
      rd(STATUS_OFS);
      chk("clr", 16'h0000, d & 8'h48);
      wr(CNT_LO_OFS, 8'h00);
      cyc = 0;
      while (comparePinOneOut !== 1'b1 && cyc < 200)
      begin
        tick(1);
        cyc++;
      end
      // Core cycles from reload to match, nT[k] per tick; one more tick unless divide by two
      e = nT[k] * (((cmpM[0] + 4) & 65535) + (k ? 1 : 0));
      chk("cyc", 16'h0001, cyc >= e - nT[k] + 2 && cyc <= e + 3 + 4 * (k / 3));
      chk("irq", 16'h0001, timerIrq);
      chk("pinTwo", 16'h0000, comparePinTwoOut);
      rd(STATUS_OFS);
      chk("set", 16'h0048, d & 8'h48);
      cpuIrqMask <= 1'b1;
      tick(1);
      chk("mask", 16'h0000, timerIrq);
      cpuIrqMask <= 1'b0;
      wr(CMP_ONE_LO_OFS, 8'h00);
      wr(CMP_TWO_LO_OFS, 8'h00);
      tick(0);
      chk("irqClr", 16'h0000, timerIrq);
    end
    extRun <= 1'b0;
    wr(CTRL_TWO_OFS, 8'h06);
    wr(CTRL_ONE_OFS, 8'h82);
    rdCnt(c0);
    pinReq <= 2'b11;
    tick(6);
    rdCnt(c1);
    rd(STATUS_OFS);
    chk("cap", 16'h0090, d & 8'h90);
    chk("capIrq", 16'h0001, timerIrq);
    rd(CAP_ONE_HI_OFS);
    v = d * 256;
    pinReq <= 2'b10;
    tick(6);
    pinReq <= 2'b11;
    tick(6);
    rd(CAP_ONE_LO_OFS);
    v += d;
    chk("capVal", 16'h0001, v >= c0 && v <= c1);
    rd(STATUS_OFS);
    chk("lock", 16'h0000, d & 8'h80);
    rd(CAP_TWO_LO_OFS);
    wr(CTRL_TWO_OFS, 8'h04);
    pinReq <= 2'b01;
    tick(6);
    rd(STATUS_OFS);
    chk("fall", 16'h0010, d & 8'h10);
    rd(CAP_TWO_HI_OFS);
    v = d * 256;
    rd(CAP_TWO_LO_OFS);
    chk("last", 16'h0001, v + d > c1);
    wr(CTRL_TWO_OFS, 8'h14);
    // Pin one latch is high from the last match; a force to low must be ignored
    wr(CTRL_ONE_OFS, 8'h88);
    tick(1);
    chk("pwmForce", 16'h0001, comparePinOneOut);
    pinReq <= 2'b00;
    tick(6);
    pinReq <= 2'b01;
    tick(6);
    rd(STATUS_OFS);
    chk("pwm", 16'h0000, d & 8'h80);
    summarize();
  end
endmodule
`default_nettype wire

// ==== test/tcc_pins.sv ====
`timescale 1ns/1ps
`default_nettype none
module tcc_pins
(
  // Clock and requests
  input wire logic core_clk,
  input wire logic extRun,
  input wire logic [1:0] pinReq,
  // Timer input pins
  output logic capturePinOne,
  output logic capturePinTwo,
  output logic externalTimerClockPin
);
  logic [1:0] divQ = 2'h0;
  logic extQ = 1'b0;
  // Period of 8 cycles, still outside runs
  always @(posedge core_clk)
  begin
    divQ <= divQ + 2'h1;
    extQ <= extRun && (extQ ^ (divQ == 2'h3));
  end
  // Skewed off the edge, as an async source
  assign #3 capturePinOne = pinReq[0];
  assign #3 capturePinTwo = pinReq[1];
  assign #3 externalTimerClockPin = extQ;
endmodule
`default_nettype wire
